// >>> rtl/smcfe_dev.sv
// Serial slave front end of a byte memory: mode detection, opcode decode,
// address capture, status register and write latch.
// Assumes link pins are asynchronous; the memory array sits on the user side.
//
// Behaviour
// - Sample on rising, shift out on falling
// - All bytes travel most significant bit first
// - Two address bytes, low 13 bits used
// - Master sends zeros in ignored address bits
// - First eight bits after select are opcode
// - Bad opcode: ignore rest, output stays floating
// - Clock level at select picks mode 0/3
// - First rising edge after select is bit one
// - Master parks clock at mode idle level
// - Decode 06h set, 04h clear latch
// - Decode 05h status read, 01h write
// - Decode 03h read, 02h write, nothing else
// - Reset leaves write latch cleared
// - Writes need write latch set first
// - Set command sets latch, shown in status
// - Status write data never changes latch flag
// - Clear latch on select rise after writes
// - Clear command clears latch, reads zero
// - Eight-bit status register
// - Master waits power-up delay before select
// - Deselected: ignore input, output floating
// - One opcode per select period
// - Latch flag sits in status bit one
`timescale 1ns/1ns
module smcfe_dev
  import smcfe_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Serial link
  smcfe_if.device link,
  // Memory side
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic [7:0] mem_rd_data_i,
  output logic mem_wr_o,
  output logic [7:0] mem_wr_data_o,
  // Status
  output logic [7:0] status_o,
  output logic mode3_o,
  output logic bad_opcode_o
);

  // ==========================================================================
  // Pin synchronisation and edge detection
  // ==========================================================================
  logic [2:0] pins_s;     // {~cs_n, sck, mosi} after two flops
  logic cs_n_s;
  logic sck_s;
  logic mosi_s;
  logic sck_d_ff;         // Previous synchronised clock level
  logic cs_n_d_ff;        // Previous synchronised select level
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  smcfe_sync #(.W(3)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i({~link.cs_n, link.sck, link.mosi}),
    .q_o(pins_s)
  );

  // Select travels inverted so the flops' reset value reads as deselected
  assign cs_n_s = ~pins_s[2];
  assign sck_s = pins_s[1];
  assign mosi_s = pins_s[0];
  // Edges are taken only from the synchronised copy, one cycle apart
  assign sck_rise = sck_s & ~sck_d_ff;
  assign sck_fall = ~sck_s & sck_d_ff;
  assign cs_rise = cs_n_s & ~cs_n_d_ff;

  // ==========================================================================
  // State
  // ==========================================================================
  smcfe_dev_state_e state_ff, nxt_state;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;      // Bit within byte or address
  logic [7:0] rx_sh_ff, nxt_rx_sh;          // Incoming byte
  logic [7:0] tx_sh_ff, nxt_tx_sh;          // Outgoing byte remainder
  logic miso_ff, nxt_miso;
  logic addr_rd_ff, nxt_addr_rd;            // Address belongs to a read
  logic latch_ff, nxt_latch;                // Write latch
  logic clr_pend_ff, nxt_clr_pend;          // Clear latch at select rise
  logic [7:0] prot_ff, nxt_prot;            // Writable status bits only
  logic mode3_ff, nxt_mode3;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic rd_ff, nxt_rd;
  logic wr_ff, nxt_wr;
  logic [7:0] wr_data_ff, nxt_wr_data;
  logic bad_ff, nxt_bad;
  logic [7:0] rx_byte;                      // Byte completed by this edge
  logic [7:0] status;                       // Live status image
  logic [7:0] out_src;                      // Byte to start shifting out

  assign rx_byte = {rx_sh_ff[6:0], mosi_s};

  // Reserved bits read zero; latch flag is bit one
  always_comb begin
    status = prot_ff & STAT_WRITABLE_MASK;
    status[STAT_WRITE_LATCH_BIT] = latch_ff;
  end

  assign out_src = (state_ff == DEV_STAT_OUT) ? status : mem_rd_data_i;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_miso = miso_ff;
    nxt_addr_rd = addr_rd_ff;
    nxt_latch = latch_ff;
    nxt_clr_pend = clr_pend_ff;
    nxt_prot = prot_ff;
    nxt_mode3 = mode3_ff;
    nxt_addr = addr_ff;
    nxt_rd = 1'b0;
    nxt_wr = 1'b0;
    nxt_wr_data = wr_data_ff;
    nxt_bad = 1'b0;
    // Select rise ends a write command: drop the latch
    if (cs_rise && clr_pend_ff) begin
      nxt_latch = 1'b0;
      nxt_clr_pend = 1'b0;
    end
    if (cs_n_s) begin
      // Deselected: nothing is shifted in, output released
      nxt_state = DEV_IDLE;
    end else begin
      unique case (state_ff)
        DEV_IDLE: begin
          // Fresh selection; clock level now decides the mode
          nxt_mode3 = sck_s;
          nxt_bit_cnt = 4'h0;
          nxt_state = DEV_OPCODE;
        end
        DEV_OPCODE: begin
          // Counting starts at the first rising edge, so a mode 3 opening fall is skipped
          if (sck_rise) begin
            nxt_rx_sh = rx_byte;
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == LAST_BYTE_BIT) begin
              nxt_bit_cnt = 4'h0;
              nxt_addr_rd = (rx_byte == OP_MEM_READ);
              case (rx_byte)
                OP_SET_WRITE_LATCH: begin
                  nxt_latch = 1'b1;
                  nxt_state = DEV_IGNORE;
                end
                OP_CLEAR_WRITE_LATCH: begin
                  nxt_clr_pend = 1'b1;
                  nxt_state = DEV_IGNORE;
                end
                OP_READ_STATUS: nxt_state = DEV_STAT_OUT;
                OP_WRITE_STATUS: begin
                  nxt_clr_pend = 1'b1;
                  nxt_state = DEV_STAT_IN;
                end
                OP_MEM_READ: nxt_state = DEV_ADDR;
                OP_MEM_WRITE: begin
                  nxt_clr_pend = 1'b1;
                  nxt_state = DEV_ADDR;
                end
                default: begin
                  // Unknown opcode: deaf and silent until the next selection
                  nxt_bad = 1'b1;
                  nxt_state = DEV_IGNORE;
                end
              endcase
            end
          end
        end
        DEV_ADDR: begin
          // Sixteen bits shift through; the top three fall off the end
          if (sck_rise) begin
            nxt_addr = {addr_ff[ADDR_W-2:0], mosi_s};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == LAST_ADDR_BIT) begin
              nxt_bit_cnt = 4'h0;
              nxt_rd = addr_rd_ff;
              nxt_state = addr_rd_ff ? DEV_RD_DATA : DEV_WR_DATA;
            end
          end
        end
        DEV_WR_DATA, DEV_STAT_IN: begin
          if (sck_rise) begin
            nxt_rx_sh = rx_byte;
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == LAST_BYTE_BIT) begin
              nxt_bit_cnt = 4'h0;
              if (state_ff == DEV_WR_DATA) begin
                // Refused silently while the latch is clear
                nxt_wr = latch_ff;
                nxt_wr_data = rx_byte;
              end else begin
                // Latch flag in the sent byte is masked off
                if (latch_ff) begin
                  nxt_prot = rx_byte & STAT_WRITABLE_MASK;
                end
                nxt_state = DEV_IGNORE;
              end
            end
          end
        end
        DEV_RD_DATA, DEV_STAT_OUT: begin
          // Output moves on falling edges; bit counter still runs on rising ones
          if (sck_rise) begin
            nxt_bit_cnt = (bit_cnt_ff == LAST_BYTE_BIT) ? 4'h0 : bit_cnt_ff + 4'h1;
          end
          if (sck_fall) begin
            if (bit_cnt_ff == 4'h0) begin
              nxt_miso = out_src[7];
              nxt_tx_sh = {out_src[6:0], 1'b0};
            end else begin
              nxt_miso = tx_sh_ff[7];
              nxt_tx_sh = {tx_sh_ff[6:0], 1'b0};
            end
          end
        end
        DEV_IGNORE: nxt_state = DEV_IGNORE;
        default: nxt_state = DEV_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_ff <= DEV_IDLE;
      bit_cnt_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'h00;
      miso_ff <= 1'b0;
      addr_rd_ff <= 1'b0;
      latch_ff <= 1'b0;
      clr_pend_ff <= 1'b0;
      prot_ff <= STATUS_RESET;
      mode3_ff <= 1'b0;
      addr_ff <= '0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      wr_data_ff <= 8'h00;
      bad_ff <= 1'b0;
      sck_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      rx_sh_ff <= nxt_rx_sh;
      tx_sh_ff <= nxt_tx_sh;
      miso_ff <= nxt_miso;
      addr_rd_ff <= nxt_addr_rd;
      latch_ff <= nxt_latch;
      clr_pend_ff <= nxt_clr_pend;
      prot_ff <= nxt_prot;
      mode3_ff <= nxt_mode3;
      addr_ff <= nxt_addr;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      wr_data_ff <= nxt_wr_data;
      bad_ff <= nxt_bad;
      sck_d_ff <= sck_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Drive only in the return phase of reads; floating everywhere else
  assign link.miso_oe = (state_ff == DEV_RD_DATA) || (state_ff == DEV_STAT_OUT);
  assign link.miso_drv = miso_ff;
  assign mem_addr_o = addr_ff;
  assign mem_rd_o = rd_ff;
  assign mem_wr_o = wr_ff;
  assign mem_wr_data_o = wr_data_ff;
  assign status_o = status;
  assign mode3_o = mode3_ff;
  assign bad_opcode_o = bad_ff;

endmodule : smcfe_dev

// >>> rtl/smcfe_pkg.sv
// Shared constants for the serial memory command front end: timing, opcodes,
// status layout and the state encodings of both ends.
// Assumes a 20 MHz system clock on both ends.
package smcfe_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 50;       // System clock period
  localparam int SCK_PERIOD_NS = 400;      // Serial clock period made by the master
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int POWER_UP_DELAY_NS = 1000; // Plain default, not a device figure
  localparam int POWER_UP_CYC = (POWER_UP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Opcodes
  // ==========================================================================
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;

  // ==========================================================================
  // Field layout and reset values
  // ==========================================================================
  localparam int ADDR_W = 13;              // Used address bits
  localparam logic [3:0] LAST_BYTE_BIT = 4'h7;
  localparam logic [3:0] LAST_ADDR_BIT = 4'hF;
  localparam int STAT_WRITE_LATCH_BIT = 1;
  localparam logic [7:0] STAT_WRITABLE_MASK = 8'h8C; // Bits 7, 3 and 2
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int HOST_SHIFT_W = 32;        // Up to four bytes a frame

  // ==========================================================================
  // State encodings
  // ==========================================================================
  typedef enum logic [7:0] {
    DEV_IDLE = 8'h01, DEV_OPCODE = 8'h02, DEV_ADDR = 8'h04, DEV_WR_DATA = 8'h08,
    DEV_RD_DATA = 8'h10, DEV_STAT_IN = 8'h20, DEV_STAT_OUT = 8'h40, DEV_IGNORE = 8'h80
  } smcfe_dev_state_e;

  typedef enum logic [6:0] {
    HST_WAIT = 7'h01, HST_IDLE = 7'h02, HST_PRE = 7'h04, HST_SEL = 7'h08,
    HST_LOW = 7'h10, HST_HIGH = 7'h20, HST_TAIL = 7'h40
  } smcfe_host_state_e;

endpackage : smcfe_pkg

// >>> rtl/smcfe_if.sv
// Four-wire serial link between the master end and the memory front end.
// Assumes the master drives select, clock and data in; the device drives
// data out only while its enable is high, otherwise the line is pulled high.
`timescale 1ns/1ns
interface smcfe_if;
  // ==========================================================================
  // Link wires
  // ==========================================================================
  logic cs_n;      // Chip select, active low
  logic sck;       // Serial clock
  logic mosi;      // Master to device data
  logic miso_drv;  // Device output value
  logic miso_oe;   // Device output enable
  wire miso;       // Resolved line seen by the master

  // Released line reads high, as through a pull-up
  assign miso = miso_oe ? miso_drv : 1'b1;

  modport device (input cs_n, input sck, input mosi, output miso_drv, output miso_oe);
  modport host (output cs_n, output sck, output mosi, input miso);
endinterface : smcfe_if

// >>> rtl/smcfe_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to clk_sys_i; only q_o may be read.
`timescale 1ns/1ns
module smcfe_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // ==========================================================================
  // One pair of flops per bit
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_ff; // First stage, read only by the second
      logic sync_ff; // Second stage
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= d_i[g];
          sync_ff <= meta_ff;
        end
      end
      assign q_o[g] = sync_ff;
    end
  endgenerate
endmodule : smcfe_sync

// >>> rtl/smcfe_host.sv
// Master end: waits the power-up delay, then runs one frame of one to four
// bytes per request, making the serial clock by dividing the system clock.
// Assumes the device answers on the shared data-out line.
`timescale 1ns/1ns
module smcfe_host
  import smcfe_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Serial link
  smcfe_if.host link,
  // Frame request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_mode3_i,
  input wire logic [2:0] req_len_i,
  input wire logic [HOST_SHIFT_W-1:0] req_data_i,
  // Frame result
  output logic done_o,
  output logic [HOST_SHIFT_W-1:0] rx_data_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  smcfe_host_state_e state_ff, nxt_state;
  logic [15:0] tmr_ff, nxt_tmr;               // Phase and power-up timer
  logic [5:0] bits_ff, nxt_bits;              // Bits left in the frame
  logic [HOST_SHIFT_W-1:0] tx_ff, nxt_tx;
  logic [HOST_SHIFT_W-1:0] rx_ff, nxt_rx;
  logic mode3_ff, nxt_mode3;
  logic cs_n_ff, nxt_cs_n;
  logic sck_ff, nxt_sck;
  logic done_ff, nxt_done;
  logic miso_s;                               // Synchronised return data
  logic tmr_end;

  smcfe_sync #(.W(1)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(link.miso),
    .q_o(miso_s)
  );

  assign tmr_end = (tmr_ff == 16'h0000);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = tmr_end ? tmr_ff : tmr_ff - 16'h0001;
    nxt_bits = bits_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_mode3 = mode3_ff;
    nxt_cs_n = cs_n_ff;
    nxt_sck = sck_ff;
    nxt_done = 1'b0;
    unique case (state_ff)
      HST_WAIT: begin
        // No selection until the device has had time to wake
        if (tmr_end) begin
          nxt_state = HST_IDLE;
        end
      end
      HST_IDLE: begin
        if (req_valid_i) begin
          nxt_mode3 = req_mode3_i;
          nxt_sck = req_mode3_i;
          nxt_tx = req_data_i;
          nxt_rx = '0;
          nxt_bits = {req_len_i, 3'b000};
          nxt_tmr = 16'(SCK_HALF_CYC - 1);
          nxt_state = HST_PRE;
        end
      end
      HST_PRE: begin
        // Clock parks at its idle level before select falls
        if (tmr_end) begin
          nxt_cs_n = 1'b0;
          nxt_tmr = 16'(SCK_HALF_CYC - 1);
          nxt_state = HST_SEL;
        end
      end
      HST_SEL: begin
        if (tmr_end) begin
          nxt_sck = 1'b0;
          nxt_tmr = 16'(SCK_HALF_CYC - 1);
          nxt_state = HST_LOW;
        end
      end
      HST_LOW: begin
        if (tmr_end) begin
          nxt_sck = 1'b1;
          nxt_tmr = 16'(SCK_HALF_CYC - 1);
          nxt_state = HST_HIGH;
        end
      end
      HST_HIGH: begin
        // Sample late in the high half, well after the device's output settled
        if (tmr_end) begin
          nxt_rx = {rx_ff[HOST_SHIFT_W-2:0], miso_s};
          nxt_bits = bits_ff - 6'd1;
          nxt_tmr = 16'(SCK_HALF_CYC - 1);
          if (bits_ff == 6'd1) begin
            nxt_sck = mode3_ff;
            nxt_state = HST_TAIL;
          end else begin
            nxt_sck = 1'b0;
            nxt_tx = {tx_ff[HOST_SHIFT_W-2:0], 1'b0};
            nxt_state = HST_LOW;
          end
        end
      end
      HST_TAIL: begin
        if (tmr_end) begin
          nxt_cs_n = 1'b1;
          nxt_done = 1'b1;
          nxt_state = HST_IDLE;
        end
      end
      default: nxt_state = HST_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_ff <= HST_WAIT;
      tmr_ff <= 16'(POWER_UP_CYC);
      bits_ff <= 6'd0;
      tx_ff <= '0;
      rx_ff <= '0;
      mode3_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      bits_ff <= nxt_bits;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      mode3_ff <= nxt_mode3;
      cs_n_ff <= nxt_cs_n;
      sck_ff <= nxt_sck;
      done_ff <= nxt_done;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign link.cs_n = cs_n_ff;
  assign link.sck = sck_ff;
  assign link.mosi = tx_ff[HOST_SHIFT_W-1];
  assign req_ready_o = (state_ff == HST_IDLE);
  assign done_o = done_ff;
  assign rx_data_o = rx_ff;

endmodule : smcfe_host

// >>> sim/smcfe_assertions.sv
// Link checker for the serial memory front end.
// Assumes it watches the wires between the two ends on the system clock.
`timescale 1ns/1ns
module smcfe_assertions
  import smcfe_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link wires
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe,
  input wire logic miso
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic sck_q_ff, nxt_sck_q;    // Last clock level, for edge finding
  logic [5:0] cnt_ff, nxt_cnt;  // Rising edges in this selection
  logic [7:0] sh_ff, nxt_sh;    // Bits sampled so far
  logic rd_op_ff, nxt_rd_op;    // Opcode of this frame may return data
  logic rise;
  logic stat_hit;               // Eighth bit completes a status read

  // Tracks bits as the device should sample them
  always_comb begin
    rise = !cs_n && sck && !sck_q_ff;
    nxt_sck_q = sck;
    nxt_sh = sh_ff;
    nxt_cnt = cs_n ? 6'h00 : cnt_ff;
    nxt_rd_op = (!cs_n && cnt_ff == 6'h00) ? 1'b0 : rd_op_ff;
    stat_hit = rise && cnt_ff == 6'h07 && {sh_ff[6:0], mosi} == OP_READ_STATUS;
    if (rise) begin
      nxt_sh = {sh_ff[6:0], mosi};
      nxt_cnt = cnt_ff + 6'h01;
      if (cnt_ff == 6'h07) begin
        nxt_rd_op = nxt_sh == OP_READ_STATUS || nxt_sh == OP_MEM_READ;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sck_q_ff <= 1'b0;
      cnt_ff <= 6'h00;
      sh_ff <= 8'h00;
      rd_op_ff <= 1'b0;
    end else begin
      sck_q_ff <= nxt_sck_q;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rd_op_ff <= nxt_rd_op;
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  idle_float_a: assert property (cs_n [*4] |-> !miso_oe)
    else $error("data out driven while deselected");
  oe_read_only_a: assert property (miso_oe |-> rd_op_ff)
    else $error("data out driven outside a read");
  stat_oe_a: assert property (stat_hit |-> ##[1:8] miso_oe)
    else $error("status read gave no output");
  out_on_fall_a: assert property (miso_oe && $rose(sck) |=> $stable(miso_drv) [*4])
    else $error("data out moved after rising clock");
  bit_count_a: assert property ($rose(cs_n) |-> cnt_ff[2:0] == 3'h0)
    else $error("frame not whole bytes");
  mosi_hold_a: assert property ($rose(sck) |=> $stable(mosi) [*3])
    else $error("data in moved while clock high");
  sel_park_a: assert property ($fell(cs_n) |=> $stable(sck) [*3])
    else $error("clock moved at selection");
  half_low_a: assert property ($fell(sck) && !cs_n |=> !sck [*3])
    else $error("clock low half too short");

  cover property (stat_hit);
  cover property ($rose(miso_oe));
  cover property ($fell(cs_n) && sck);
endmodule : smcfe_assertions

// >>> sim/tb.sv
// Self-checking bench: the master end drives the memory front end.
// Assumes both ends share clk_sys_i; the bench plays the memory array.
`timescale 1ns/1ns
module tb;
  import smcfe_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0, req_ready_o, req_mode3_i = 1'b0, done_o;
  logic [2:0] req_len_i = 3'h1;
  logic [31:0] req_data_i = 32'h0000_0000, rx_data_o;
  logic [ADDR_W-1:0] mem_addr_o, wr_a, a;
  logic mem_rd_o, mem_wr_o, mode3_o, bad_opcode_o;
  logic [7:0] mem_rd_data_i = 8'h00, mem_wr_data_o, status_o, wr_d, d, op;
  int miscompares = 0, tests_run = 0, done_cnt = 0, wr_cnt = 0, bad_cnt = 0, rd_cnt = 0;
  int seed = 32'hb227e58b;
  logic [31:0] eq[$], mq[$];    // Expected receive value and its mask

  always #25 clk_sys_i = ~clk_sys_i;

  smcfe_if u_smcfe_if();
  smcfe_host u_smcfe_host(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(u_smcfe_if), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_mode3_i(req_mode3_i), .req_len_i(req_len_i), .req_data_i(req_data_i),
    .done_o(done_o), .rx_data_o(rx_data_o));
  smcfe_dev u_smcfe_dev(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(u_smcfe_if), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_rd_data_i(mem_rd_data_i), .mem_wr_o(mem_wr_o), .mem_wr_data_o(mem_wr_data_o),
    .status_o(status_o), .mode3_o(mode3_o), .bad_opcode_o(bad_opcode_o));
  smcfe_assertions u_smcfe_assertions(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n(u_smcfe_if.cs_n),
    .sck(u_smcfe_if.sck), .mosi(u_smcfe_if.mosi), .miso_drv(u_smcfe_if.miso_drv),
    .miso_oe(u_smcfe_if.miso_oe), .miso(u_smcfe_if.miso));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // One frame; bounded waits for ready and for done, then settle time
  task automatic frame(input logic m3, input logic [2:0] n, input logic [31:0] dat, input logic [31:0] msk,
                       input logic [31:0] ex);
    int k;
    int c;
    k = 0;
    while (req_ready_o !== 1'b1 && k < 400) begin
      @(negedge clk_sys_i);
      k++;
    end
    if (k >= 400) begin
      miscompares++;
      results();
    end
    eq.push_back(ex);
    mq.push_back(msk);
    c = done_cnt;
    req_mode3_i = m3;
    req_len_i = n;
    req_data_i = dat;
    req_valid_i = 1'b1;
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    k = 0;
    while (done_cnt == c && k < 800) begin
      @(negedge clk_sys_i);
      k++;
    end
    if (k >= 800) begin
      miscompares++;
      results();
    end
    repeat (6) @(negedge clk_sys_i);
  endtask : frame

  // Monitor: received data against the oldest note, and memory-side events
  always @(negedge clk_sys_i) begin
    if (done_o === 1'b1) begin
      check(rx_data_o & mq.pop_front(), eq.pop_front());
      done_cnt++;
    end
    if (mem_wr_o === 1'b1) begin
      wr_cnt++;
      wr_a = mem_addr_o;
      wr_d = mem_wr_data_o;
    end
    if (bad_opcode_o === 1'b1) bad_cnt++;
    if (mem_rd_o === 1'b1) rd_cnt++;
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    check(status_o, 8'h00);
    repeat (POWER_UP_CYC / 2) @(negedge clk_sys_i);
    check(req_ready_o, 1'b0);
    frame(1'b0, 3'h2, {OP_READ_STATUS, 24'h0}, 32'hFF, 32'h0);
    frame(1'b0, 3'h2, {OP_WRITE_STATUS, 8'h8C, 16'h0}, 32'h0, 32'h0);
    check(status_o, 8'h00);
    $display("test reset and locked status done");
    frame(1'b1, 3'h1, {OP_SET_WRITE_LATCH, 24'h0}, 32'h0, 32'h0);
    check(status_o, 8'h02);
    check(mode3_o, 1'b1);
    frame(1'b1, 3'h2, {OP_READ_STATUS, 24'h0}, 32'hFF, 32'h02);
    frame(1'b0, 3'h2, {OP_WRITE_STATUS, 8'hFF, 16'h0}, 32'h0, 32'h0);
    check(status_o, 8'h8C);
    frame(1'b0, 3'h1, {OP_SET_WRITE_LATCH, 24'h0}, 32'h0, 32'h0);
    frame(1'b0, 3'h1, {OP_CLEAR_WRITE_LATCH, 24'h0}, 32'h0, 32'h0);
    frame(1'b0, 3'h2, {OP_READ_STATUS, 24'h0}, 32'hFF, 32'h8C);
    check(mode3_o, 1'b0);
    $display("test latch and status done");
    a = $random(seed);
    d = $random(seed);
    frame(1'b0, 3'h4, {OP_MEM_WRITE, 3'b000, a, d}, 32'h0, 32'h0);
    check(wr_cnt, 0);
    frame(1'b0, 3'h1, {OP_SET_WRITE_LATCH, 24'h0}, 32'h0, 32'h0);
    frame(1'b1, 3'h4, {OP_MEM_WRITE, 3'b000, a, d}, 32'h0, 32'h0);
    check(wr_cnt, 1);
    check(wr_a, a);
    check(wr_d, d);
    check(status_o, 8'h8C);
    mem_rd_data_i = $random(seed);
    a = $random(seed);
    frame(1'b0, 3'h4, {OP_MEM_READ, 3'b000, a, 8'h00}, 32'hFF, {24'h0, mem_rd_data_i});
    check(mem_addr_o, a);
    check(rd_cnt, 1);
    $display("test memory access done");
    for (int i = 0; i < 4; i++) begin
      op = $random(seed);
      if (op inside {OP_SET_WRITE_LATCH, OP_CLEAR_WRITE_LATCH, OP_READ_STATUS, OP_WRITE_STATUS,
                     OP_MEM_READ, OP_MEM_WRITE}) op = 8'hFF;
      frame(1'b0, 3'h2, {op, OP_READ_STATUS, 16'h0}, 32'h0, 32'h0);
      check(bad_cnt, i + 1);
    end
    $display("test undefined opcodes done");
    results();
  end
endmodule : tb
